// >>> slo_pkg.sv
// constants, register map and field layout for the serdes lane status/override bank
// assumes a single 250 MHz clock and a plain strobe register port
// Notes on behaviour
// - registers decode at base 0x800 plus offset
// - lane registers at 0x000..0x034, clock module at 0x420 and 0x428
// - status register shows power-up control inputs, read-only
// - with override on, the status tx boost field no longer shows the value in use
// - loss filter mode read-only in status bits 29:28
// - rx equalizer setting in status bits 23:21, reset 010
// - half-rate selection in status bit 16
// - tx boost code in status bits 9:6, reset 1011
// - boost code n gives -20log10(1-(n+0.5)/32) dB, code 0 none
// - override bit 31 puts only the tx boost bits 25:22 in force, resets to 0
// - tx boost override in bits 25:22, reset 0, same encoding
// - loss-of-signal output read-only at bit 2
// - loss filter 00 off, 11 heavy: 128 cycles of no signal; others reserved
package slo_pkg;

    localparam logic [11:0] BASE_ADDR        = 12'h800;
    localparam logic [11:0] OFS_TXRX_STAT    = 12'h000;
    localparam logic [11:0] OFS_OUT_STAT     = 12'h004;
    localparam logic [11:0] OFS_RX_TX_OVERRIDE_ENABLE      = 12'h008;
    localparam logic [11:0] OFS_PAT_GEN      = 12'h00C;
    localparam logic [11:0] OFS_PAT_MATCH    = 12'h02C;
    localparam logic [11:0] OFS_PHASE_ERR    = 12'h030;
    localparam logic [11:0] OFS_SCOPE_FI     = 12'h034;
    localparam logic [11:0] OFS_CLK_STAT     = 12'h420;
    localparam logic [11:0] OFS_CLK_TX_OVERRIDE_ENABLE     = 12'h428;
    localparam logic [11:0] OFS_IRQ_STATUS   = 12'h500;
    localparam logic [11:0] OFS_IRQ_MASK     = 12'h504;

    // status register field positions
    localparam int          LFM_LSB          = 28;
    localparam int          EQ_LSB           = 21;
    localparam int          HALF_RATE_BIT    = 16;
    localparam int          BOOST_LSB        = 6;
    localparam int          ALIGN_BIT        = 19;
    // override register field positions
    localparam int          OVR_EN_BIT       = 31;
    localparam int          OVR_BOOST_LSB    = 22;
    localparam int          PRESERVE_LSB     = 3;
    localparam int          LOST_BIT         = 2;

    localparam logic [1:0]  RST_STAT_HI      = 2'h1;
    localparam logic [5:0]  RST_STAT_MID     = 6'h20;
    localparam logic [2:0]  RST_EQ           = 3'h2;
    localparam logic [3:0]  RST_BOOST        = 4'hB;
    localparam logic [3:0]  RST_OVR_BOOST    = 4'h0;
    localparam logic [18:0] RST_PRESERVE     = 19'h00000;

    localparam logic [1:0]  LFM_OFF          = 2'h0;
    localparam logic [1:0]  LFM_HEAVY        = 2'h3;
    localparam int          HEAVY_CYCLES     = 128;
    localparam logic [7:0]  HEAVY_CNT        = 8'(HEAVY_CYCLES - 1);

    // interrupt events
    localparam int          EV_LOST          = 0;
    localparam int          EV_REGAIN        = 1;
    localparam int          EV_ERR           = 2;
    localparam int          EV_W             = 3;

    typedef struct packed {
        logic [1:0] loss_filter_mode;
        logic [2:0] rx_equalizer_setting;
        logic       align_en;
        logic       half_rate;
        logic [3:0] tx_boost;
    } slo_txrx_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } slo_req_s;

endpackage

// >>> slo_regs.sv
// serdes lane status/override register bank with loss filter and interrupt
// assumes power-up control inputs and raw loss pin are asynchronous to ref_clk_in
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module slo_regs
(
    input  wire logic              ref_clk_in,
    input  wire logic              arst_n_in,
    input  wire logic [11:0]       addr_in,
    input  wire logic [31:0]       wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    input  wire slo_pkg::slo_txrx_s pwrup_in,
    input  wire logic              raw_signal_lost_in,
    output logic [31:0]            rdata_out,
    output logic [3:0]             tx_boost_out,
    output logic                   signal_lost_flag_out,
    output logic                   irq_out
);

    slo_pkg::slo_req_s req;
    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // three-stage synchronisers; stage one only feeds stage two
    logic [10:0] pu_s1;
    logic [10:0] pu_s2;
    logic [10:0] pu_s3;
    logic        los_s1;
    logic        los_s2;
    logic        los_s3;
    // chains carry no reset: they refill while reset is held, so the capture
    // right after release sees live inputs and not cleared stages
    always_ff @(posedge ref_clk_in)
    begin
        pu_s1  <= pwrup_in;
        pu_s2  <= pu_s1;
        pu_s3  <= pu_s2;
        los_s1 <= raw_signal_lost_in;
        los_s2 <= los_s1;
        los_s3 <= los_s2;
    end

    // full-address decode helper, used by both read and write paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == (slo_pkg::BASE_ADDR + ofs));
    endfunction

    // power-up capture: taken once after reset release, when inputs settle
    typedef enum logic [1:0]
    {
        SLO_WAIT   = 2'b00,
        SLO_SETTLE = 2'b01,
        SLO_DONE   = 2'b10
    } slo_cap_e;

    slo_cap_e          cap_st;
    slo_cap_e          next_cap_st;
    slo_pkg::slo_txrx_s stat;
    slo_pkg::slo_txrx_s next_stat;
    logic              ovr_en;
    logic              next_ovr_en;
    logic [3:0]        ovr_boost;
    logic [3:0]        next_ovr_boost;
    logic [18:0]       preserve_on_write_field;
    logic [18:0]       next_preserve;
    logic [4:0]        ovr_rsvd;
    logic [4:0]        next_ovr_rsvd;

    // capture state and override register
    always_comb
    begin
        next_cap_st    = cap_st;
        next_stat      = stat;
        next_ovr_en    = ovr_en;
        next_ovr_boost = ovr_boost;
        next_preserve  = preserve_on_write_field;
        next_ovr_rsvd  = ovr_rsvd;
        unique case (cap_st)
            SLO_WAIT:
                next_cap_st = SLO_SETTLE;
            SLO_SETTLE:
            begin
                // wait for stages two and three to agree before sampling
                if (pu_s2 == pu_s3)
                begin
                    next_stat   = pu_s3;
                    next_cap_st = SLO_DONE;
                end
            end
            SLO_DONE:
                next_cap_st = SLO_DONE;
            default:
                next_cap_st = SLO_WAIT;
        endcase
        // status register has no write path at all
        if (req.wr && hit(req.addr, slo_pkg::OFS_OUT_STAT))
        begin
            next_ovr_en    = req.wdata[slo_pkg::OVR_EN_BIT];
            next_ovr_rsvd  = req.wdata[30:26];
            next_ovr_boost = req.wdata[slo_pkg::OVR_BOOST_LSB +: 4];
            next_preserve  = req.wdata[slo_pkg::PRESERVE_LSB +: 19];
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cap_st                  <= SLO_WAIT;
            stat                    <= '{slo_pkg::LFM_OFF, slo_pkg::RST_EQ, 1'b0, 1'b0,
                                         slo_pkg::RST_BOOST};
            ovr_en                  <= 1'b0;
            ovr_boost               <= slo_pkg::RST_OVR_BOOST;
            preserve_on_write_field <= slo_pkg::RST_PRESERVE;
            ovr_rsvd                <= 5'h00;
        end
        else
        begin
            cap_st                  <= next_cap_st;
            stat                    <= next_stat;
            ovr_en                  <= next_ovr_en;
            ovr_boost               <= next_ovr_boost;
            preserve_on_write_field <= next_preserve;
            ovr_rsvd                <= next_ovr_rsvd;
        end
    end

    // loss filter: heavy mode needs 128 consecutive lost cycles
    logic [7:0] lost_cnt;
    logic [7:0] next_lost_cnt;
    logic       lost;
    logic       next_lost;
    logic       agreed_lost_q;
    logic       next_agreed;
    always_comb
    begin
        next_agreed   = (los_s2 == los_s3) ? los_s3 : agreed_lost_q;
        next_lost_cnt = lost_cnt;
        next_lost     = lost;
        unique case (stat.loss_filter_mode)
            slo_pkg::LFM_HEAVY:
            begin
                if (!agreed_lost_q)
                begin
                    next_lost_cnt = 8'h00;
                    next_lost     = 1'b0;
                end
                else if (lost_cnt == slo_pkg::HEAVY_CNT)
                    next_lost = 1'b1;
                else
                    next_lost_cnt = 8'(lost_cnt + 8'h01);
            end
            // off and reserved codes pass the flag straight through
            default:
            begin
                next_lost_cnt = 8'h00;
                next_lost     = agreed_lost_q;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            lost_cnt      <= 8'h00;
            lost          <= 1'b0;
            agreed_lost_q <= 1'b0;
        end
        else
        begin
            lost_cnt      <= next_lost_cnt;
            lost          <= next_lost;
            agreed_lost_q <= next_agreed;
        end
    end

    // interrupts: sticky status, write one to clear, set wins over clear
    logic [slo_pkg::EV_W-1:0] irq_stat;
    logic [slo_pkg::EV_W-1:0] next_irq_stat;
    logic [slo_pkg::EV_W-1:0] irq_mask;
    logic [slo_pkg::EV_W-1:0] next_irq_mask;
    logic [slo_pkg::EV_W-1:0] ev;
    logic                     lost_d;
    logic                     next_lost_d;
    logic                     bad_acc;
    always_comb
    begin
        next_lost_d = lost;
        bad_acc     = (req.wr || req.rd) && (req.addr[11:0] < slo_pkg::BASE_ADDR);
        ev          = '0;
        ev[slo_pkg::EV_LOST]   = lost && !lost_d;
        ev[slo_pkg::EV_REGAIN] = !lost && lost_d;
        ev[slo_pkg::EV_ERR]    = bad_acc;
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        if (req.wr && hit(req.addr, slo_pkg::OFS_IRQ_STATUS))
            next_irq_stat = irq_stat & ~req.wdata[slo_pkg::EV_W-1:0];
        if (req.wr && hit(req.addr, slo_pkg::OFS_IRQ_MASK))
            next_irq_mask = req.wdata[slo_pkg::EV_W-1:0];
        next_irq_stat = next_irq_stat | ev;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            irq_stat <= '0;
            irq_mask <= '0;
            lost_d   <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            lost_d   <= next_lost_d;
        end
    end

    // read mux and driven outputs; unmapped and unused offsets read zero
    logic [31:0] next_rdata;
    logic [31:0] stat_word;
    logic [31:0] ovr_word;
    logic [3:0]  next_boost;
    always_comb
    begin
        stat_word = '0;
        stat_word[31:30] = slo_pkg::RST_STAT_HI;
        stat_word[slo_pkg::LFM_LSB +: 2] = stat.loss_filter_mode;
        stat_word[slo_pkg::EQ_LSB +: 3]  = stat.rx_equalizer_setting;
        stat_word[slo_pkg::ALIGN_BIT]    = stat.align_en;
        stat_word[slo_pkg::HALF_RATE_BIT] = stat.half_rate;
        stat_word[15:10] = slo_pkg::RST_STAT_MID;
        stat_word[slo_pkg::BOOST_LSB +: 4] = stat.tx_boost;
        ovr_word = '0;
        ovr_word[slo_pkg::OVR_EN_BIT]       = ovr_en;
        ovr_word[30:26]                     = ovr_rsvd;
        ovr_word[slo_pkg::OVR_BOOST_LSB +: 4] = ovr_boost;
        ovr_word[slo_pkg::PRESERVE_LSB +: 19] = preserve_on_write_field;
        ovr_word[slo_pkg::LOST_BIT]         = lost;
        next_rdata = 32'h0000_0000;
        if (req.rd)
        begin
            if (hit(req.addr, slo_pkg::OFS_TXRX_STAT))
                next_rdata = stat_word;
            else if (hit(req.addr, slo_pkg::OFS_OUT_STAT))
                next_rdata = ovr_word;
            else if (hit(req.addr, slo_pkg::OFS_IRQ_STATUS))
                next_rdata = {29'h0, irq_stat};
            else if (hit(req.addr, slo_pkg::OFS_IRQ_MASK))
                next_rdata = {29'h0, irq_mask};
        end
        // status field keeps power-up value even while override drives the pin
        next_boost = ovr_en ? ovr_boost : stat.tx_boost;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rdata_out            <= 32'h0000_0000;
            tx_boost_out         <= slo_pkg::RST_BOOST;
            signal_lost_flag_out <= 1'b0;
            irq_out              <= 1'b0;
        end
        else
        begin
            rdata_out            <= next_rdata;
            tx_boost_out         <= next_boost;
            signal_lost_flag_out <= lost;
            irq_out              <= |(next_irq_stat & next_irq_mask);
        end
    end

endmodule

// >>> slo_regs_sva.sv
// port-level assertions for the lane status/override register bank
// assumes pwrup_in only changes while arst_n_in is low
`timescale 1ns/100ps
module slo_regs_sva
(
    input wire logic               ref_clk_in,
    input wire logic               arst_n_in,
    input wire logic [11:0]        addr_in,
    input wire logic [31:0]        wdata_in,
    input wire logic               wr_in,
    input wire logic               rd_in,
    input wire slo_pkg::slo_txrx_s pwrup_in,
    input wire logic               raw_signal_lost_in,
    input wire logic [31:0]        rdata_out,
    input wire logic [3:0]         tx_boost_out,
    input wire logic               signal_lost_flag_out,
    input wire logic               irq_out
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_rd_idle; !rd_in |=> rdata_out == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    property p_stat_fix;
        rd_in && addr_in == 12'h800 |=> rdata_out[31:30] == 2'h1 && rdata_out[15:10] == 6'h20;
    endproperty
    a_stat_fix: assert property (p_stat_fix) else $error("status fixed fields wrong");
    property p_eq;
        rd_in && addr_in == 12'h800 |=> rdata_out[23:21] == pwrup_in.rx_equalizer_setting;
    endproperty
    a_eq: assert property (p_eq) else $error("equalizer field wrong");
    property p_unmapped;
        rd_in && addr_in inside {12'h808, 12'h80C, 12'h82C, 12'h830, 12'h834, 12'hC20, 12'hC28}
            |=> rdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unbacked offset read nonzero");
    property p_boost_ovr;
        wr_in && addr_in == 12'h804 && wdata_in[31]
            |-> ##2 tx_boost_out == $past(wdata_in[25:22], 2);
    endproperty
    a_boost_ovr: assert property (p_boost_ovr) else $error("override boost not in force");
    property p_boost_pwr;
        wr_in && addr_in == 12'h804 && !wdata_in[31] |-> ##2 tx_boost_out == pwrup_in.tx_boost;
    endproperty
    a_boost_pwr: assert property (p_boost_pwr) else $error("power-up boost not in force");
    property p_lost_clr; !raw_signal_lost_in [*8] |-> !signal_lost_flag_out; endproperty
    a_lost_clr: assert property (p_lost_clr) else $error("loss flag stuck high");
    property p_lost_pass;
        (pwrup_in.loss_filter_mode == 2'h0 && raw_signal_lost_in) [*8] |-> signal_lost_flag_out;
    endproperty
    a_lost_pass: assert property (p_lost_pass) else $error("unfiltered loss not passed");
    property p_heavy;
        pwrup_in.loss_filter_mode == 2'h3 && $rose(raw_signal_lost_in)
            |=> !signal_lost_flag_out [*8];
    endproperty
    a_heavy: assert property (p_heavy) else $error("heavy filter flagged early");
endmodule

bind slo_regs slo_regs_sva u_sva
(
    .ref_clk_in           (ref_clk_in),
    .arst_n_in            (arst_n_in),
    .addr_in              (addr_in),
    .wdata_in             (wdata_in),
    .wr_in                (wr_in),
    .rd_in                (rd_in),
    .pwrup_in             (pwrup_in),
    .raw_signal_lost_in   (raw_signal_lost_in),
    .rdata_out            (rdata_out),
    .tx_boost_out         (tx_boost_out),
    .signal_lost_flag_out (signal_lost_flag_out),
    .irq_out              (irq_out)
);

// >>> serdes_lane_status_override_regs_tb_top.sv
// self-checking bench for the lane status/override register bank
// assumes power-up inputs are changed only while reset is held
`timescale 1ns/100ps
module serdes_lane_status_override_regs_tb_top;
    logic               clk = 1'b0;
    logic               arst_n = 1'b0;
    logic [11:0]        addr = 12'h0;
    logic [31:0]        wdata = 32'h0;
    logic               wr = 1'b0;
    logic               rd = 1'b0;
    slo_pkg::slo_txrx_s pw = {2'h0, 3'h5, 1'b1, 1'b1, 4'h3};
    logic               raw = 1'b0;
    logic [31:0]        rdata;
    logic [3:0]         boost;
    logic               lost;
    logic               irq;
    logic [31:0]        rv;
    logic               irq_a;
    int                 error_cnt = 0;
    int                 num_checks = 0;

    always #2 clk = ~clk;

    slo_regs dut
    (
        .ref_clk_in           (clk),
        .arst_n_in            (arst_n),
        .addr_in              (addr),
        .wdata_in             (wdata),
        .wr_in                (wr),
        .rd_in                (rd),
        .pwrup_in             (pw),
        .raw_signal_lost_in   (raw),
        .rdata_out            (rdata),
        .tx_boost_out         (boost),
        .signal_lost_flag_out (lost),
        .irq_out              (irq)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one-cycle strobes, released at the edge that samples them
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic logic [31:0] stat_exp(input slo_pkg::slo_txrx_s p);
        return {2'h1, p.loss_filter_mode, 4'h0, p.rx_equalizer_setting, 1'b0, p.align_en,
                2'h0, p.half_rate, 6'h20, p.tx_boost, 6'h0};
    endfunction

    // reset values are checked while reset is still held
    // power-up inputs only move while reset is held
    task automatic do_reset(input logic [1:0] lfm);
        @(posedge clk);
        arst_n              <= 1'b0;
        pw.loss_filter_mode <= lfm;
        repeat (3) @(posedge clk);
        chk(rdata, 32'h0);
        chk({27'h0, boost, lost}, {27'h0, 4'hB, 1'b0});
        chk({31'h0, irq}, 32'h0);
        arst_n <= 1'b1;
        repeat (10) @(posedge clk);
    endtask

    task automatic t_status();
        rd_reg(12'h800, rv); chk(rv, stat_exp(pw));
        wr_reg(12'h800, 32'hFFFFFFFF);
        rd_reg(12'h800, rv); chk(rv, stat_exp(pw));
    endtask

    task automatic t_override();
        rd_reg(12'h804, rv); chk(rv, 32'h0);
        for (int n = 0; n < 16; n++)
        begin
            wr_reg(12'h804, {1'b1, 5'h15, 4'(n), 19'h5A5A5, 3'h0});
            @(posedge clk);
            #1 chk({28'h0, boost}, 32'(n));
        end
        rd_reg(12'h804, rv); chk(rv, {1'b1, 5'h15, 4'hF, 19'h5A5A5, 3'h0});
        rd_reg(12'h800, rv); chk(rv, stat_exp(pw));
        wr_reg(12'h804, 32'h0);
        @(posedge clk);
        #1 chk({28'h0, boost}, {28'h0, pw.tx_boost});
        wr_reg(12'h804, 32'h80400000);
        @(posedge clk);
        #1 chk({28'h0, boost}, 32'h1);
    endtask

    task automatic t_unmapped();
        logic [11:0] al [8] = '{12'h808, 12'h80C, 12'h82C, 12'h830, 12'h834,
                                12'hC20, 12'hC28, 12'h900};
        foreach (al[i])
        begin
            wr_reg(al[i], 32'hFFFFFFFF);
            rd_reg(al[i], rv); chk(rv, 32'h0);
        end
        rd_reg(12'h004, rv); chk(rv, 32'h0);
    endtask

    // irq mask polarity is left to the design, so only its effect is compared
    task automatic t_loss_irq();
        @(posedge clk);
        raw <= 1'b1;
        repeat (10) @(posedge clk);
        #1 chk({31'h0, lost}, 32'h1);
        rd_reg(12'h804, rv); chk({31'h0, rv[2]}, 32'h1);
        rd_reg(12'hD00, rv); chk({29'h0, rv[2:0]}, 32'h5);
        wr_reg(12'hD04, 32'h0);
        #1 irq_a = irq;
        wr_reg(12'hD04, 32'h7);
        #1 chk({31'h0, irq_a ^ irq}, 32'h1);
        @(posedge clk);
        raw <= 1'b0;
        repeat (10) @(posedge clk);
        #1 chk({31'h0, lost}, 32'h0);
        rd_reg(12'hD00, rv); chk(rv, 32'h7);
        wr_reg(12'hD00, 32'hFFFFFFFF);
        rd_reg(12'hD00, rv); chk(rv, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_heavy();
        do_reset(2'h3);
        rd_reg(12'h804, rv); chk(rv, 32'h0);
        rd_reg(12'h800, rv); chk(rv, stat_exp(pw));
        @(posedge clk);
        raw <= 1'b1;
        repeat (120) @(posedge clk);
        #1 chk({31'h0, lost}, 32'h0);
        repeat (20) @(posedge clk);
        #1 chk({31'h0, lost}, 32'h1);
        @(posedge clk);
        raw <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk({31'h0, lost}, 32'h0);
    endtask

    // watchdog against a hung run
    initial
    begin
        #400000;
        error_cnt++;
        test_done();
    end

    initial
    begin
        do_reset(2'h0);
        t_status();
        t_override();
        t_unmapped();
        t_loss_irq();
        t_heavy();
        test_done();
    end
endmodule
